// file: verilog/cfd_pkg.sv
package cfd_pkg;
    // ---------------------------------------------
    // flag bits and reset values
    // ---------------------------------------------
    localparam int CCR_C = 0;
    localparam int CCR_V = 1;
    localparam int CCR_Z = 2;
    localparam int CCR_N = 3;
    localparam int CCR_H = 5;
    localparam logic [7:0] CCR_RESET = 8'h80;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [15:0] PAGE_BASE = 16'hff00;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    // ---------------------------------------------
    // first-byte codes
    // ---------------------------------------------
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam logic [7:0] OPC_SLEEP = 8'h01;
    localparam logic [7:0] OPC_STC = 8'h02;
    localparam logic [7:0] OPC_LDC_REG = 8'h03;
    localparam logic [7:0] OPC_ORC = 8'h04;
    localparam logic [7:0] OPC_FLAGS_XOR_IMM = 8'h05;
    localparam logic [7:0] OPC_FLAGS_AND_IMM = 8'h06;
    localparam logic [7:0] OPC_LDC_IMM = 8'h07;
    localparam logic [7:0] OPC_RTS = 8'h54;
    localparam logic [7:0] OPC_RTE = 8'h56;
    localparam logic [7:0] OPC_CALL_REG = 8'h59;
    localparam logic [7:0] OPC_CALL_ABS = 8'h5a;
    localparam logic [7:0] OPC_CALL_IND = 8'h5b;
    localparam logic [7:0] OPC_COPY = 8'h7b;
    // ---------------------------------------------
    // state counts
    // ---------------------------------------------
    localparam int CW = 11;
    localparam logic [CW-1:0] ST_SHORT = 11'h002;
    localparam logic [CW-1:0] ST_CALL_REG = 11'h006;
    localparam logic [CW-1:0] ST_CALL_LONG = 11'h008;
    localparam logic [CW-1:0] ST_RTE = 11'h00a;
    localparam logic [CW-1:0] ST_COPY_BASE = 11'h009;
    localparam logic [15:0] LEN_SHORT = 16'h0002;
    localparam logic [15:0] LEN_LONG = 16'h0004;
    localparam logic [CW-1:0] CNT_IND_RD = 11'h004;
    localparam logic [CW-1:0] CNT_RTE_RD = 11'h005;
    typedef enum logic [3:0] {OP_NONE, OP_CALL_REG, OP_CALL_ABS, OP_CALL_IND, OP_RTS, OP_RTE, OP_SLEEP,
        OP_LDC_IMM, OP_LDC_REG, OP_STC, OP_FLAGS_AND_IMM, OP_ORC, OP_FLAGS_XOR_IMM, OP_NOP, OP_COPY} cfd_op_t;
    typedef enum logic [2:0] {ALU_ADDX, ALU_SUBX, ALU_ADDW, ALU_SUBW, ALU_DAA, ALU_DAS, ALU_DIV} cfd_alu_op_t;
    typedef struct packed {logic [15:0] word0; logic [15:0] word1;} cfd_insn_t;
    typedef struct packed {logic req; logic we; logic word; logic [15:0] addr; logic [15:0] wdata;} cfd_mem_t;
    typedef struct packed {logic valid; cfd_alu_op_t op; logic [15:0] a; logic [15:0] b;} cfd_alu_t;
    typedef struct packed {logic [7:0] count; logic [15:0] src; logic [15:0] dst;} cfd_copy_t;
endpackage : cfd_pkg

// file: verilog/cfd_state_timer.sv
`timescale 1ns/1ps
module cfd_state_timer #(
    parameter int W = 11
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [W-1:0] i_value,
    output logic [W-1:0] o_count,
    output logic o_busy
);
    logic [W-1:0] count_reg;
    logic busy_reg;
    // -------------------------------------------
    // one count per state, last state at zero
    // -------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            count_reg <= '0;
            busy_reg <= 1'b0;
        end else if (i_load) begin
            count_reg <= i_value;
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            count_reg <= (count_reg == '0) ? '0 : count_reg - 1'b1;
            busy_reg <= (count_reg != '0);
        end
    end
    assign o_count = count_reg;
    assign o_busy = busy_reg;
endmodule : cfd_state_timer

// file: verilog/cfd_flag_notes.sv
`timescale 1ns/1ps
module cfd_flag_notes (
    input wire cfd_pkg::cfd_alu_t i_alu,
    input wire logic [7:0] i_ccr,
    output logic [7:0] o_ccr
);
    import cfd_pkg::*;
    logic [8:0] r9;
    logic [16:0] r17;
    logic [12:0] r13;
    logic [4:0] r5;
    logic lo_adj;
    logic hi_adj;
    // -------------------------------------------
    // footnoted flag behaviour
    // -------------------------------------------
    always_comb begin
        o_ccr = i_ccr;
        r9 = '0;
        r17 = '0;
        r13 = '0;
        r5 = '0;
        lo_adj = 1'b0;
        hi_adj = 1'b0;
        unique case (i_alu.op)
            ALU_ADDX, ALU_SUBX: begin
                r9 = (i_alu.op == ALU_ADDX) ? {1'b0, i_alu.a[7:0]} + {1'b0, i_alu.b[7:0]} + {8'h00, i_ccr[CCR_C]}
                    : {1'b0, i_alu.a[7:0]} - {1'b0, i_alu.b[7:0]} - {8'h00, i_ccr[CCR_C]};
                r5 = (i_alu.op == ALU_ADDX) ? {1'b0, i_alu.a[3:0]} + {1'b0, i_alu.b[3:0]} + {4'h0, i_ccr[CCR_C]}
                    : {1'b0, i_alu.a[3:0]} - {1'b0, i_alu.b[3:0]} - {4'h0, i_ccr[CCR_C]};
                o_ccr[CCR_C] = r9[8];
                o_ccr[CCR_H] = r5[4];
                o_ccr[CCR_N] = r9[7];
                o_ccr[CCR_Z] = (r9[7:0] == 8'h00) ? i_ccr[CCR_Z] : 1'b0;
                o_ccr[CCR_V] = (i_alu.op == ALU_ADDX) ? (i_alu.a[7] == i_alu.b[7]) && (r9[7] != i_alu.a[7])
                    : (i_alu.a[7] != i_alu.b[7]) && (r9[7] != i_alu.a[7]);
            end
            ALU_ADDW, ALU_SUBW: begin
                r17 = (i_alu.op == ALU_ADDW) ? {1'b0, i_alu.a} + {1'b0, i_alu.b} : {1'b0, i_alu.a} - {1'b0, i_alu.b};
                r13 = (i_alu.op == ALU_ADDW) ? {1'b0, i_alu.a[11:0]} + {1'b0, i_alu.b[11:0]}
                    : {1'b0, i_alu.a[11:0]} - {1'b0, i_alu.b[11:0]};
                o_ccr[CCR_H] = r13[12];
                o_ccr[CCR_C] = r17[16];
                o_ccr[CCR_N] = r17[15];
                o_ccr[CCR_Z] = (r17[15:0] == 16'h0000);
                o_ccr[CCR_V] = (i_alu.op == ALU_ADDW) ? (i_alu.a[15] == i_alu.b[15]) && (r17[15] != i_alu.a[15])
                    : (i_alu.a[15] != i_alu.b[15]) && (r17[15] != i_alu.a[15]);
            end
            ALU_DAA, ALU_DAS: begin
                lo_adj = i_ccr[CCR_H] || ((i_alu.op == ALU_DAA) && (i_alu.a[3:0] > 4'h9));
                hi_adj = i_ccr[CCR_C] || ((i_alu.op == ALU_DAA) && (i_alu.a[7:0] > 8'h99));
                r9 = (i_alu.op == ALU_DAA)
                    ? {1'b0, i_alu.a[7:0]} + (lo_adj ? 9'h006 : 9'h000) + (hi_adj ? 9'h060 : 9'h000)
                    : {1'b0, i_alu.a[7:0]} - (lo_adj ? 9'h006 : 9'h000) - (hi_adj ? 9'h060 : 9'h000);
                o_ccr[CCR_C] = hi_adj ? 1'b1 : i_ccr[CCR_C];
                o_ccr[CCR_N] = r9[7];
                o_ccr[CCR_Z] = (r9[7:0] == 8'h00);
            end
            ALU_DIV: begin
                o_ccr[CCR_N] = i_alu.b[7];
                o_ccr[CCR_Z] = (i_alu.b[7:0] == 8'h00);
            end
            default: o_ccr = i_ccr;
        endcase
    end
endmodule : cfd_flag_notes

// file: verilog/cfd_control_flow_decode.sv
`timescale 1ns/1ps
module cfd_control_flow_decode (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_issue,
    input wire cfd_pkg::cfd_insn_t i_insn,
    input wire logic [15:0] i_reg_word,
    input wire logic [7:0] i_reg_byte,
    input wire cfd_pkg::cfd_copy_t i_copy,
    input wire cfd_pkg::cfd_alu_t i_alu,
    input wire logic [15:0] i_mem_rdata,
    input wire logic i_wake,
    output logic o_busy,
    output logic o_done,
    output logic o_reject,
    output logic o_sleep,
    output cfd_pkg::cfd_mem_t o_mem,
    output logic [15:0] o_program_counter,
    output logic [15:0] o_stack_pointer,
    output logic [7:0] o_ccr,
    output cfd_pkg::cfd_copy_t o_copy,
    output logic o_store_flags_valid,
    output logic [7:0] o_store_flags_data
);
    import cfd_pkg::*;
    cfd_op_t op_dec;
    cfd_op_t op_reg;
    logic [CW-1:0] states_dec;
    logic [15:0] len_dec;
    logic [15:0] len_reg;
    logic [CW-1:0] cnt;
    logic busy;
    logic accept;
    logic last;
    logic copy_run;
    logic [1:0] copy_ph;
    logic [CW-1:0] copy_off;
    logic [15:0] pc_reg;
    logic [15:0] sp_reg;
    logic [7:0] ccr_reg;
    logic [7:0] ccr_alu;
    logic [15:0] tgt_reg;
    logic [7:0] imm_reg;
    logic [7:0] rbyte_reg;
    logic rd_wait_reg;
    logic rd_ccr_reg;
    logic done_reg;
    logic reject_reg;
    logic sleep_reg;
    logic stc_valid_reg;
    logic [7:0] stc_data_reg;
    cfd_mem_t mem_reg;
    cfd_copy_t copy_reg;
    // ---------------------------------------------
    // decode
    // ---------------------------------------------
    always_comb begin
        op_dec = OP_NONE;
        states_dec = ST_SHORT;
        len_dec = LEN_SHORT;
        case (i_insn.word0[15:8])
            OPC_NOP: op_dec = OP_NOP;
            OPC_SLEEP: op_dec = i_insn.word0[7] ? OP_SLEEP : OP_NONE;
            OPC_STC: op_dec = OP_STC;
            OPC_LDC_REG: op_dec = OP_LDC_REG;
            OPC_ORC: op_dec = OP_ORC;
            OPC_FLAGS_XOR_IMM: op_dec = OP_FLAGS_XOR_IMM;
            OPC_FLAGS_AND_IMM: op_dec = OP_FLAGS_AND_IMM;
            OPC_LDC_IMM: op_dec = OP_LDC_IMM;
            OPC_RTS: begin
                op_dec = OP_RTS;
                states_dec = ST_CALL_LONG;
            end
            OPC_RTE: begin
                op_dec = OP_RTE;
                states_dec = ST_RTE;
            end
            OPC_CALL_REG: begin
                op_dec = OP_CALL_REG;
                states_dec = ST_CALL_REG;
            end
            OPC_CALL_ABS: begin
                op_dec = OP_CALL_ABS;
                states_dec = ST_CALL_LONG;
                len_dec = LEN_LONG;
            end
            OPC_CALL_IND: begin
                op_dec = OP_CALL_IND;
                states_dec = ST_CALL_LONG;
            end
            OPC_COPY: begin
                op_dec = i_insn.word0[7] ? OP_NONE : OP_COPY;
                states_dec = ST_COPY_BASE + {1'b0, i_copy.count, 2'b00};
                len_dec = LEN_LONG;
            end
            // push and pop are ordinary transfer_data codes; handled elsewhere
            default: op_dec = OP_NONE;
        endcase
    end
    assign accept = i_issue && !busy && (op_dec != OP_NONE);
    assign last = busy && (cnt == '0);
    // copy region: four states per byte above the fixed tail
    assign copy_run = busy && (op_reg == OP_COPY) && (cnt >= ST_COPY_BASE);
    assign copy_off = cnt - ST_COPY_BASE;
    assign copy_ph = copy_off[1:0];
    cfd_state_timer #(.W(CW)) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_load(accept),
        .i_value(states_dec - 1'b1),
        .o_count(cnt),
        .o_busy(busy)
    );
    cfd_flag_notes u_flags (
        .i_alu(i_alu),
        .i_ccr(ccr_reg),
        .o_ccr(ccr_alu)
    );
    // ---------------------------------------------
    // instruction latch and handshake
    // ---------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            op_reg <= OP_NONE;
            len_reg <= LEN_SHORT;
            imm_reg <= 8'h00;
            rbyte_reg <= 8'h00;
        end else if (accept) begin
            op_reg <= op_dec;
            len_reg <= len_dec;
            imm_reg <= i_insn.word0[7:0];
            rbyte_reg <= i_reg_byte;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            done_reg <= 1'b0;
            reject_reg <= 1'b0;
        end else begin
            done_reg <= busy && (cnt == 11'h001);
            reject_reg <= i_issue && !accept;
        end
    end
    // ---------------------------------------------
    // memory requests
    // ---------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mem_reg <= '0;
            rd_wait_reg <= 1'b0;
            rd_ccr_reg <= 1'b0;
        end else begin
            mem_reg <= '0;
            rd_wait_reg <= mem_reg.req && !mem_reg.we;
            if (accept) begin
                unique case (op_dec)
                    OP_CALL_REG, OP_CALL_ABS, OP_CALL_IND: begin
                        mem_reg <= '{req: 1'b1, we: 1'b1, word: 1'b1, addr: sp_reg - WORD_STEP,
                            wdata: pc_reg + len_dec};
                    end
                    OP_RTS, OP_RTE: begin
                        mem_reg <= '{req: 1'b1, we: 1'b0, word: 1'b1, addr: sp_reg, wdata: 16'h0000};
                        rd_ccr_reg <= (op_dec == OP_RTE);
                    end
                    default: mem_reg <= '0;
                endcase
            end else if (busy && (op_reg == OP_CALL_IND) && (cnt == CNT_IND_RD)) begin
                mem_reg <= '{req: 1'b1, we: 1'b0, word: 1'b1, addr: PAGE_BASE | {8'h00, imm_reg},
                    wdata: 16'h0000};
                rd_ccr_reg <= 1'b0;
            end else if (busy && (op_reg == OP_RTE) && (cnt == CNT_RTE_RD)) begin
                mem_reg <= '{req: 1'b1, we: 1'b0, word: 1'b1, addr: sp_reg, wdata: 16'h0000};
                rd_ccr_reg <= 1'b0;
            end else if (copy_run && (copy_ph == 2'd3)) begin
                mem_reg <= '{req: 1'b1, we: 1'b0, word: 1'b0, addr: copy_reg.src, wdata: 16'h0000};
            end else if (copy_run && (copy_ph == 2'd1)) begin
                // read data is used the edge after it arrives, no holding register
                mem_reg <= '{req: 1'b1, we: 1'b1, word: 1'b0, addr: copy_reg.dst,
                    wdata: {8'h00, i_mem_rdata[7:0]}};
            end
        end
    end
    // ---------------------------------------------
    // block copy registers
    // ---------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            copy_reg <= '0;
        end else if (accept && (op_dec == OP_COPY)) begin
            copy_reg <= i_copy;
        end else if (copy_run && (copy_ph == 2'd0)) begin
            copy_reg.src <= copy_reg.src + 16'h0001;
            copy_reg.dst <= copy_reg.dst + 16'h0001;
            copy_reg.count <= copy_reg.count - 8'h01;
        end
    end
    // ---------------------------------------------
    // stack pointer, target and program counter
    // ---------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sp_reg <= SP_RESET;
        end else if (accept && (op_dec inside {OP_CALL_REG, OP_CALL_ABS, OP_CALL_IND})) begin
            sp_reg <= sp_reg - WORD_STEP;
        end else if (rd_wait_reg && (op_reg inside {OP_RTS, OP_RTE})) begin
            sp_reg <= sp_reg + WORD_STEP;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            tgt_reg <= 16'h0000;
        end else if (accept) begin
            tgt_reg <= (op_dec == OP_CALL_REG) ? i_reg_word : i_insn.word1;
        end else if (rd_wait_reg && !rd_ccr_reg && (op_reg != OP_COPY)) begin
            tgt_reg <= i_mem_rdata;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pc_reg <= PC_RESET;
        end else if (last) begin
            if (op_reg inside {OP_CALL_REG, OP_CALL_ABS, OP_CALL_IND, OP_RTS, OP_RTE}) begin
                pc_reg <= tgt_reg;
            end else begin
                pc_reg <= pc_reg + len_reg;
            end
        end
    end
    // ---------------------------------------------
    // flag register
    // ---------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ccr_reg <= CCR_RESET;
        end else if (rd_wait_reg && rd_ccr_reg) begin
            ccr_reg <= i_mem_rdata[15:8];
        end else if (last && (op_reg inside {OP_LDC_IMM, OP_LDC_REG, OP_FLAGS_AND_IMM, OP_ORC, OP_FLAGS_XOR_IMM})) begin
            unique case (op_reg)
                OP_LDC_IMM: ccr_reg <= imm_reg;
                OP_LDC_REG: ccr_reg <= rbyte_reg;
                OP_FLAGS_AND_IMM: ccr_reg <= ccr_reg & imm_reg;
                OP_ORC: ccr_reg <= ccr_reg | imm_reg;
                default: ccr_reg <= ccr_reg ^ imm_reg;
            endcase
        end else if (i_alu.valid && !busy) begin
            // arithmetic flag updates only between our own instructions
            ccr_reg <= ccr_alu;
        end
    end
    // ---------------------------------------------
    // sleep and flag store
    // ---------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sleep_reg <= 1'b0;
        end else if (last && (op_reg == OP_SLEEP)) begin
            sleep_reg <= 1'b1;
        end else if (i_wake) begin
            sleep_reg <= 1'b0;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            stc_valid_reg <= 1'b0;
            stc_data_reg <= 8'h00;
        end else begin
            stc_valid_reg <= last && (op_reg == OP_STC);
            stc_data_reg <= ccr_reg;
        end
    end
    assign o_busy = busy;
    assign o_done = done_reg;
    assign o_reject = reject_reg;
    assign o_sleep = sleep_reg;
    assign o_mem = mem_reg;
    assign o_program_counter = pc_reg;
    assign o_stack_pointer = sp_reg;
    assign o_ccr = ccr_reg;
    assign o_copy = copy_reg;
    assign o_store_flags_valid = stc_valid_reg;
    assign o_store_flags_data = stc_data_reg;
    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    property p_call_reg_time;
        @(posedge i_sys_clk) disable iff (i_rst) accept && (op_dec == OP_CALL_REG) |-> !o_done [*6] ##1 o_done;
    endproperty
    a_call_reg_time: assert property (p_call_reg_time) else $error("register call not 6 states");
    property p_call_abs;
        logic [15:0] w;
        @(posedge i_sys_clk) disable iff (i_rst)
        (accept && (op_dec == OP_CALL_ABS), w = i_insn.word1) |-> ##8 o_done ##1 (o_program_counter == w);
    endproperty
    a_call_abs: assert property (p_call_abs) else $error("absolute call wrong");
    property p_call_push;
        @(posedge i_sys_clk) disable iff (i_rst) accept && (op_dec == OP_CALL_IND)
        |=> o_mem.req && o_mem.we && (o_mem.addr == o_stack_pointer) && (o_stack_pointer == $past(sp_reg) - 16'h0002);
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");
    property p_rts;
        @(posedge i_sys_clk) disable iff (i_rst) accept && (op_dec == OP_RTS)
        |-> ##8 o_done && (o_stack_pointer == $past(sp_reg, 8) + 16'h0002) && (o_ccr == $past(ccr_reg, 8));
    endproperty
    a_rts: assert property (p_rts) else $error("return wrong");
    property p_rte;
        @(posedge i_sys_clk) disable iff (i_rst) accept && (op_dec == OP_RTE)
        |-> ##10 o_done && (o_stack_pointer == $past(sp_reg, 10) + 16'h0004);
    endproperty
    a_rte: assert property (p_rte) else $error("exception return wrong");
    property p_sleep;
        @(posedge i_sys_clk) disable iff (i_rst) accept && (op_dec == OP_SLEEP) && !i_wake
        |-> ##2 o_done && !o_sleep ##1 o_sleep || $past(i_wake);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
    property p_orc;
        @(posedge i_sys_clk) disable iff (i_rst) accept && (op_dec == OP_ORC)
        |-> ##3 (o_ccr == ($past(ccr_reg, 3) | $past(i_insn.word0[7:0], 3)));
    endproperty
    a_orc: assert property (p_orc) else $error("flag or wrong");
    property p_copy_time;
        @(posedge i_sys_clk) disable iff (i_rst) accept && (op_dec == OP_COPY) && (i_copy.count == 8'h01)
        |-> !o_done [*8] ##1 !o_done [*5] ##1 o_done ##1 (o_copy.count == 8'h00);
    endproperty
    a_copy_time: assert property (p_copy_time) else $error("copy timing wrong");
    property p_nop;
        @(posedge i_sys_clk) disable iff (i_rst) accept && (op_dec == OP_NOP)
        |-> ##3 (o_program_counter == $past(pc_reg, 3) + 16'h0002) && !o_mem.req;
    endproperty
    a_nop: assert property (p_nop) else $error("nop wrong");
endmodule : cfd_control_flow_decode

// file: bench/cfd_mem_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// program, data and stack memory, zero wait
// ---------------------------------------------
module cfd_mem_model (
    input wire logic i_sys_clk,
    input wire cfd_pkg::cfd_mem_t i_mem,
    output logic [15:0] o_rdata
);
    import cfd_pkg::*;
    logic [7:0] mem [0:65535];
    initial o_rdata = 16'h5a5a;
    // plain always so the bench may preload bytes directly
    always @(posedge i_sys_clk) begin
        // no stale data outside the answer cycle
        o_rdata <= ~o_rdata;
        if (i_mem.req && i_mem.we && i_mem.word) begin
            mem[i_mem.addr] <= i_mem.wdata[15:8];
            mem[i_mem.addr + 16'h0001] <= i_mem.wdata[7:0];
        end
        if (i_mem.req && i_mem.we && !i_mem.word) begin
            mem[i_mem.addr] <= i_mem.wdata[7:0];
        end
        if (i_mem.req && !i_mem.we) begin
            o_rdata <= i_mem.word ? {mem[i_mem.addr], mem[i_mem.addr + 16'h0001]} : {~o_rdata[15:8], mem[i_mem.addr]};
        end
    end
endmodule : cfd_mem_model

// file: bench/cfd_control_flow_decode_test.sv
`timescale 1ns/1ps
module cfd_control_flow_decode_test;
    import cfd_pkg::*;
    logic i_sys_clk, i_rst, i_issue, i_wake, o_busy, o_done, o_reject, o_sleep, o_store_flags_valid;
    logic [15:0] i_reg_word, i_mem_rdata, o_program_counter, o_stack_pointer;
    logic [7:0] i_reg_byte, o_ccr, o_store_flags_data;
    cfd_insn_t i_insn;
    cfd_copy_t i_copy, o_copy;
    cfd_alu_t i_alu;
    cfd_mem_t o_mem;
    int failures = 0;
    int comparisons = 0;
    cfd_control_flow_decode u_cfd_control_flow_decode (.i_sys_clk, .i_rst, .i_issue, .i_insn, .i_reg_word,
        .i_reg_byte, .i_copy, .i_alu, .i_mem_rdata, .i_wake, .o_busy, .o_done, .o_reject, .o_sleep, .o_mem,
        .o_program_counter, .o_stack_pointer, .o_ccr, .o_copy, .o_store_flags_valid, .o_store_flags_data);
    cfd_mem_model u_cfd_mem_model (.i_sys_clk, .i_mem(o_mem), .o_rdata(i_mem_rdata));
    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    task automatic conclude;
        if (failures == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // leaves the bench at the first cycle after done, when state has landed
    task automatic run(input logic [15:0] w0, input logic [15:0] w1, input int n);
        int k;
        i_insn = {w0, w1};
        i_issue = 1'b1;
        for (k = 1; k < 60; k++) begin
            @(negedge i_sys_clk);
            i_issue = 1'b0;
            if (o_done === 1'b1) break;
        end
        chk("states", 16'(n), 16'(k));
        @(negedge i_sys_clk);
    endtask : run
    task automatic rej(input logic [15:0] w0);
        logic [15:0] pc;
        pc = o_program_counter;
        i_insn = {w0, 16'h0000};
        i_issue = 1'b1;
        @(negedge i_sys_clk);
        i_issue = 1'b0;
        chk("reject", 16'h0001, {15'h0, o_reject});
        @(negedge i_sys_clk);
        chk("pc", pc, o_program_counter);
    endtask : rej
    task automatic alu(input cfd_alu_op_t op, input logic [15:0] b, input int idx, input logic e);
        i_alu = {1'b1, op, 16'h0800, b};
        @(negedge i_sys_clk);
        i_alu.valid = 1'b0;
        chk("flag", {15'h0, e}, {15'h0, o_ccr[idx]});
    endtask : alu
    task automatic pw(input logic [15:0] a, input logic [15:0] d);
        u_cfd_mem_model.mem[a] = d[15:8];
        u_cfd_mem_model.mem[a + 16'h0001] = d[7:0];
    endtask : pw
    // ---------------------------------------------
    // stimulus
    // ---------------------------------------------
    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        repeat (3000) @(posedge i_sys_clk);
        failures++;
        conclude();
    end
    initial begin
        {i_rst, i_issue, i_wake, i_insn, i_reg_word, i_reg_byte, i_copy, i_alu} = '0;
        i_rst = 1'b1;
        repeat (4) @(negedge i_sys_clk);
        i_rst = 1'b0;
        chk("ccr", 16'h0080, {8'h00, o_ccr});
        i_reg_word = 16'h1234;
        run(16'h5900, 16'h0000, 6);
        chk("pc", 16'h1234, o_program_counter);
        chk("sp", 16'hfffe, o_stack_pointer);
        run(16'h5400, 16'h0000, 8);
        chk("pc", 16'h0002, o_program_counter);
        chk("sp", 16'h0000, o_stack_pointer);
        run(16'h5a00, 16'h0400, 8);
        chk("pc", 16'h0400, o_program_counter);
        run(16'h5400, 16'h0000, 8);
        chk("pc", 16'h0006, o_program_counter);
        pw(16'hff10, 16'h0600);
        run(16'h5b10, 16'h0000, 8);
        chk("pc", 16'h0600, o_program_counter);
        run(16'h0000, 16'h0000, 2);
        chk("pc", 16'h0602, o_program_counter);
        run(16'h07a5, 16'h0000, 2);
        chk("ccr", 16'h00a5, {8'h00, o_ccr});
        run(16'h0402, 16'h0000, 2);
        chk("ccr", 16'h00a7, {8'h00, o_ccr});
        run(16'h05ff, 16'h0000, 2);
        chk("ccr", 16'h0058, {8'h00, o_ccr});
        run(16'h060f, 16'h0000, 2);
        chk("ccr", 16'h0008, {8'h00, o_ccr});
        i_reg_byte = 8'h3c;
        run(16'h0300, 16'h0000, 2);
        run(16'h0200, 16'h0000, 2);
        chk("store", 16'h013c, {7'h00, o_store_flags_valid, o_store_flags_data});
        pw(16'hfffe, 16'hc100);
        pw(16'h0000, 16'h0700);
        run(16'h5600, 16'h0000, 10);
        chk("ccr", 16'h00c1, {8'h00, o_ccr});
        chk("pc", 16'h0700, o_program_counter);
        chk("sp", 16'h0002, o_stack_pointer);
        pw(16'h0100, 16'h1122);
        pw(16'h0102, 16'h3344);
        i_copy = {8'h03, 16'h0100, 16'h0200};
        run(16'h7b00, 16'h0000, 21);
        chk("copy", 16'h1122, {u_cfd_mem_model.mem[16'h0200], u_cfd_mem_model.mem[16'h0201]});
        chk("copy", 16'h0033, {8'h00, u_cfd_mem_model.mem[16'h0202]});
        chk("src", 16'h0103, o_copy.src);
        chk("count", 16'h0000, {8'h00, o_copy.count});
        i_copy = {8'h00, 16'h0100, 16'h0300};
        run(16'h7b00, 16'h0000, 9);
        i_copy = {8'h01, 16'h0102, 16'h0300};
        run(16'h7b00, 16'h0000, 13);
        chk("copy", 16'h0033, {8'h00, u_cfd_mem_model.mem[16'h0300]});
        run(16'h0180, 16'h0000, 2);
        chk("sleep", 16'h0001, {15'h0, o_sleep});
        i_wake = 1'b1;
        @(negedge i_sys_clk);
        i_wake = 1'b0;
        @(negedge i_sys_clk);
        chk("sleep", 16'h0000, {15'h0, o_sleep});
        rej(16'h7b80);
        rej(16'h0100);
        rej(16'hff59);
        alu(ALU_ADDW, 16'h0800, CCR_H, 1'b1);
        alu(ALU_ADDW, 16'h0001, CCR_H, 1'b0);
        alu(ALU_DIV, 16'h0000, CCR_Z, 1'b1);
        alu(ALU_DIV, 16'h0080, CCR_N, 1'b1);
        alu(ALU_DIV, 16'h0080, CCR_Z, 1'b0);
        conclude();
    end
endmodule : cfd_control_flow_decode_test
